/* logic/qdac_serial_update.sv */
`timescale 1ns/10ps
`include "qdac_defs.svh"

// Notes on behaviour
// - A falling edge on async_clear_n is a clear event, acted on without any shift clock edge.
// - While async_clear_n is low, every low level or pulse on load_outputs_n is ignored.
// - A clear event loads code 0x000 into every input register and every output code register.
// - The input shift register is enabled only while frame_select_n is low.
// - serial_in is sampled on each rising shift_clock edge inside a frame.
// - The received word is committed on the sixteenth falling shift_clock edge of the frame.
// - If frame_select_n rises before that edge, the partial word is dropped and nothing changes.
// - The input shift register holds exactly sixteen bits.
// - Each serial_out bit is launched on a rising shift_clock edge for the host to take on the fall.
// - Every channel code register and the control register can be read back on serial_out.
// - A low load_outputs_n copies each input register with new data into its output code register.
// - range_select_n low selects the 0 to 60 V span, high selects the 0 to 30 V span.
// - The active-low alarm output asserts while the die temperature detector reports overheating.
// - After an overtemperature shutdown the channels stay powered down until a serial power-up.
// - The control register resets to 0x40, leaving the analog section powered down.
module qdac_serial_update
   import qdac_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic shift_clock,
   input wire logic frame_select_n,
   input wire logic serial_in,
   output logic serial_out,
   input wire logic async_clear_n,
   input wire logic load_outputs_n,
   input wire logic range_select_n,
   input wire logic overTempDetect,
   output logic alarmOut_n,
   output logic span60Sel,
   output logic pdGroundMode,
   output qdac_chan_s [3:0] chanOut
);

   // ************************************************************
   // Functions
   // ************************************************************

   // One-hot channel select for a frame address
   function automatic logic [3:0] chanHit(input logic [2:0] addr);
      logic [3:0] hit;
      hit = 4'h0;
      hit[0] = (addr == `QDAC_ADDR_CH_A);
      hit[1] = (addr == `QDAC_ADDR_CH_B);
      hit[2] = (addr == `QDAC_ADDR_CH_C);
      hit[3] = (addr == `QDAC_ADDR_CH_D);
      return hit;
   endfunction

   // ************************************************************
   // Link domain: receive
   // ************************************************************

   logic [`QDAC_CNT_BITS-1:0] bitCnt_reg;
   logic [`QDAC_FRAME_BITS-1:0] rxShift_reg;
   logic frameDone_reg;
   logic [`QDAC_FRAME_BITS-1:0] rxWord_reg;
   logic commitTog_reg;
   logic commitNow;

   // Frame strobe high holds the receiver cleared, so an early rise
   // drops the partial word even though the shift clock has stopped.
   always_ff @(posedge shift_clock or posedge frame_select_n) begin
      if (frame_select_n) begin
         bitCnt_reg <= '0;
         rxShift_reg <= '0;
      end else if (bitCnt_reg != `QDAC_CNT_FULL) begin
         rxShift_reg <= {rxShift_reg[`QDAC_FRAME_BITS-2:0], serial_in};
         bitCnt_reg <= bitCnt_reg + `QDAC_CNT_BITS'(1);
      end
   end

   // Sixteen rising edges seen means this fall is the sixteenth one
   assign commitNow = (bitCnt_reg == `QDAC_CNT_FULL) && !frameDone_reg;

   always_ff @(negedge shift_clock or posedge frame_select_n) begin
      if (frame_select_n) begin
         frameDone_reg <= 1'b0;
      end else if (commitNow) begin
         frameDone_reg <= 1'b1;
      end
   end

   // Word is held until the next commit; the toggle tells the core
   always_ff @(negedge shift_clock or negedge rst_n) begin
      if (!rst_n) begin
         rxWord_reg <= '0;
         commitTog_reg <= 1'b0;
      end else if (commitNow && !frame_select_n) begin
         rxWord_reg <= rxShift_reg;
         commitTog_reg <= ~commitTog_reg;
      end
   end

   // ************************************************************
   // Link domain: readback
   // ************************************************************

   logic [`QDAC_FRAME_BITS-1:0] readHold_reg;
   logic serialOut_reg;
   logic [3:0] txIdx;

   assign txIdx = 4'hF - bitCnt_reg[3:0];

   // Read word is quasi-static: it settles a few core cycles after
   // the read command and is not touched while the next frame runs.
   always_ff @(posedge shift_clock or posedge frame_select_n) begin
      if (frame_select_n) begin
         serialOut_reg <= 1'b0;
      end else if (bitCnt_reg != `QDAC_CNT_FULL) begin
         serialOut_reg <= readHold_reg[txIdx];
      end
   end

   assign serial_out = serialOut_reg;

   // ************************************************************
   // Core domain: synchronisers
   // ************************************************************

   logic clrMeta_reg;
   logic clrSync_reg;
   logic ldMeta_reg;
   logic ldSync_reg;
   logic rngMeta_reg;
   logic rngSync_reg;
   logic otMeta_reg;
   logic otSync_reg;
   logic togMeta_reg;
   logic togSync_reg;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         clrMeta_reg <= 1'b1;
         clrSync_reg <= 1'b1;
         ldMeta_reg <= 1'b1;
         ldSync_reg <= 1'b1;
         rngMeta_reg <= 1'b1;
         rngSync_reg <= 1'b1;
         otMeta_reg <= 1'b0;
         otSync_reg <= 1'b0;
         togMeta_reg <= 1'b0;
         togSync_reg <= 1'b0;
      end else begin
         clrMeta_reg <= async_clear_n;
         clrSync_reg <= clrMeta_reg;
         ldMeta_reg <= load_outputs_n;
         ldSync_reg <= ldMeta_reg;
         rngMeta_reg <= range_select_n;
         rngSync_reg <= rngMeta_reg;
         otMeta_reg <= overTempDetect;
         otSync_reg <= otMeta_reg;
         togMeta_reg <= commitTog_reg;
         togSync_reg <= togMeta_reg;
      end
   end

   // ************************************************************
   // Core domain: events
   // ************************************************************

   logic clrPrev_reg;
   logic otPrev_reg;
   logic togSeen_reg;
   logic clearEvt;
   logic otRise;
   logic wordEvt;
   logic loadActive;
   qdac_frame_s rxFrame;
   logic [3:0] wrChan;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         clrPrev_reg <= 1'b1;
         otPrev_reg <= 1'b0;
         togSeen_reg <= 1'b0;
      end else begin
         clrPrev_reg <= clrSync_reg;
         otPrev_reg <= otSync_reg;
         togSeen_reg <= togSync_reg;
      end
   end

   // No shift clock is involved, so a clear acts with the link idle
   assign clearEvt = clrPrev_reg && !clrSync_reg;
   assign otRise = otSync_reg && !otPrev_reg;
   assign wordEvt = togSync_reg != togSeen_reg;
   assign rxFrame = qdac_frame_s'(rxWord_reg);
   assign wrChan = (wordEvt && !rxFrame.readReq) ? chanHit(rxFrame.addr) : 4'h0;

   // Level sensed, so a tied-low load updates as each word lands
   assign loadActive = !ldSync_reg && clrSync_reg;

   // ************************************************************
   // Core domain: code registers
   // ************************************************************

   qdac_code_t inReg_reg [4];
   qdac_code_t dacReg_reg [4];
   logic [3:0] pending_reg;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < `QDAC_CHANNELS; i++) begin
            inReg_reg[i] <= `QDAC_CLEAR_CODE;
         end
      end else if (clearEvt) begin
         for (int i = 0; i < `QDAC_CHANNELS; i++) begin
            inReg_reg[i] <= `QDAC_CLEAR_CODE;
         end
      end else begin
         for (int i = 0; i < `QDAC_CHANNELS; i++) begin
            if (wrChan[i]) begin
               inReg_reg[i] <= rxFrame.data;
            end
         end
      end
   end

   // A write landing with a copy keeps its flag for the next cycle
   always_ff @(posedge clk) begin
      if (!rst_n || clearEvt) begin
         pending_reg <= 4'h0;
      end else begin
         pending_reg <= (pending_reg & ~{4{loadActive}}) | wrChan;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < `QDAC_CHANNELS; i++) begin
            dacReg_reg[i] <= `QDAC_CLEAR_CODE;
         end
      end else if (clearEvt) begin
         for (int i = 0; i < `QDAC_CHANNELS; i++) begin
            dacReg_reg[i] <= `QDAC_CLEAR_CODE;
         end
      end else begin
         for (int i = 0; i < `QDAC_CHANNELS; i++) begin
            if (loadActive && pending_reg[i]) begin
               dacReg_reg[i] <= inReg_reg[i];
            end
         end
      end
   end

   // ************************************************************
   // Core domain: control register
   // ************************************************************

   logic [`QDAC_CTRL_BITS-1:0] ctrl_reg;

   // Shutdown beats a write in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_reg <= `QDAC_CTRL_RESET;
      end else if (otRise) begin
         ctrl_reg <= ctrl_reg & ~`QDAC_CTRL_PWR_MASK;
      end else if (wordEvt && !rxFrame.readReq && rxFrame.addr == `QDAC_ADDR_CTRL) begin
         ctrl_reg <= rxFrame.data[`QDAC_CTRL_BITS-1:0];
      end
   end

   // ************************************************************
   // Core domain: read command
   // ************************************************************

   qdac_code_t readData;
   logic [3:0] rdChan;

   assign rdChan = chanHit(rxFrame.addr);

   always_comb begin
      readData = 12'h000;
      for (int i = 0; i < `QDAC_CHANNELS; i++) begin
         if (rdChan[i]) begin
            readData = dacReg_reg[i];
         end
      end
      if (rxFrame.addr == `QDAC_ADDR_CTRL) begin
         readData = {4'h0, ctrl_reg};
      end
   end

   // Unused addresses read back as zero data
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         readHold_reg <= '0;
      end else if (wordEvt && rxFrame.readReq) begin
         readHold_reg <= {1'b0, rxFrame.addr, readData};
      end
   end

   // ************************************************************
   // Core domain: outputs
   // ************************************************************

   logic alarm_reg;
   logic span60_reg;
   logic pdMode_reg;
   qdac_chan_s [3:0] chanOut_reg;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         alarm_reg <= 1'b0;
         span60_reg <= 1'b0;
         pdMode_reg <= 1'b1;
      end else begin
         alarm_reg <= otSync_reg;
         span60_reg <= !rngSync_reg;
         pdMode_reg <= ctrl_reg[`QDAC_CTRL_PDMODE_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         chanOut_reg <= '0;
      end else begin
         for (int i = 0; i < `QDAC_CHANNELS; i++) begin
            chanOut_reg[i].powered <= ctrl_reg[`QDAC_CTRL_PWR_LSB + i];
            chanOut_reg[i].code <= dacReg_reg[i];
         end
      end
   end

   assign alarmOut_n = !alarm_reg;
   assign span60Sel = span60_reg;
   assign pdGroundMode = pdMode_reg;
   assign chanOut = chanOut_reg;

endmodule

/* pkg/qdac_defs.svh */
`ifndef QDAC_DEFS_SVH
`define QDAC_DEFS_SVH

// Frame layout: bit 15 read flag, bits 14:12 address, bits 11:0 data
`define QDAC_FRAME_BITS 16
`define QDAC_CODE_BITS 12
`define QDAC_CHANNELS 4
`define QDAC_ADDR_BITS 3
`define QDAC_CNT_BITS 5
`define QDAC_CNT_FULL 5'h10

// Register addresses carried in a frame
`define QDAC_ADDR_CH_A 3'h1
`define QDAC_ADDR_CH_B 3'h2
`define QDAC_ADDR_CH_C 3'h3
`define QDAC_ADDR_CH_D 3'h4
`define QDAC_ADDR_CTRL 3'h7

// Control register
`define QDAC_CTRL_BITS 8
`define QDAC_CTRL_RESET 8'h40
`define QDAC_CTRL_PWR_LSB 2
`define QDAC_CTRL_PWR_MASK 8'h3C
`define QDAC_CTRL_PDMODE_BIT 6

// Code loaded by a clear
`define QDAC_CLEAR_CODE 12'h000

`endif

/* pkg/qdac_pkg.sv */
package qdac_pkg;

   typedef logic [11:0] qdac_code_t;

   typedef struct packed {
      logic readReq;
      logic [2:0] addr;
      qdac_code_t data;
   } qdac_frame_s;

   typedef struct packed {
      logic powered;
      qdac_code_t code;
   } qdac_chan_s;

endpackage

/* verification/qdac_host_model.sv */
`timescale 1ns/10ps
module qdac_host_model(
   output logic sclk,
   output logic fsN,
   output logic serIn,
   input wire logic serOut
);
   // Strobe rises after time zero so the receiver's clear edge is never missed
   initial begin
      sclk = 0;
      fsN = 0;
      serIn = 0;
      #1 fsN = 1;
   end
   // 6 ns link period; clock idles low between frames
   task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
      r = 16'h0000;
      fsN = 0;
      for (int i = 15; i > 15 - n; i--) begin
         serIn = w[i];
         #3 sclk = 1;
         #3 sclk = 0;
         r[i] = serOut;
      end
      #3 fsN = 1;
      serIn = ~serIn;
   endtask
endmodule

/* verification/qdac_serial_update_props.sv */
`timescale 1ns/10ps
module qdac_serial_update_props
   import qdac_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic serial_out,
   input wire logic frame_select_n,
   input wire logic async_clear_n,
   input wire logic load_outputs_n,
   input wire logic range_select_n,
   input wire logic overTempDetect,
   input wire logic alarmOut_n,
   input wire logic span60Sel,
   input wire qdac_chan_s [3:0] chanOut
);
   logic [47:0] codes;
   logic [3:0] pwr;
   logic [5:0] causeHist;
   assign codes = {chanOut[3].code, chanOut[2].code, chanOut[1].code, chanOut[0].code};
   assign pwr = {chanOut[3].powered, chanOut[2].powered, chanOut[1].powered,
      chanOut[0].powered};
   // Window of recent load or clear activity
   always_ff @(posedge clk) begin
      causeHist <= {causeHist[4:0], !load_outputs_n || !async_clear_n};
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_hot;
      overTempDetect [*5];
   endsequence
   sequence s_cool;
      !overTempDetect [*5];
   endsequence
   a_clear_zero: assert property ($fell(async_clear_n) |-> ##[2:6] codes == 48'h0)
      else $error("codes not zero after clear");
   a_clear_blocks: assert property (!async_clear_n [*8] |-> $stable(codes))
      else $error("codes moved while clear low");
   a_load_cause: assert property ($changed(codes) |-> |causeHist)
      else $error("codes moved without load");
   a_span_pin: assert property ($changed(range_select_n) |->
      ##[2:4] span60Sel == !range_select_n) else $error("span wrong");
   a_alarm_rise: assert property ($rose(overTempDetect) |-> ##[2:4] $fell(alarmOut_n))
      else $error("alarm late");
   a_alarm_hold: assert property (s_hot |-> !alarmOut_n)
      else $error("alarm missing");
   a_alarm_off: assert property (s_cool |-> alarmOut_n)
      else $error("alarm stuck");
   a_hot_unpowered: assert property (s_hot |-> pwr == 4'h0)
      else $error("powered while hot");
   a_out_idle: assert property (frame_select_n [*2] |-> !serial_out)
      else $error("output busy outside frame");
endmodule
bind qdac_serial_update qdac_serial_update_props u_props(.clk(clk), .rst_n(rst_n),
   .serial_out(serial_out), .frame_select_n(frame_select_n), .async_clear_n(async_clear_n),
   .load_outputs_n(load_outputs_n), .range_select_n(range_select_n),
   .overTempDetect(overTempDetect), .alarmOut_n(alarmOut_n), .span60Sel(span60Sel),
   .chanOut(chanOut));

/* verification/qdac_serial_update_bench.sv */
`timescale 1ns/10ps
module qdac_serial_update_bench;
   import qdac_pkg::*;
   logic clk, rst_n, sclk, fsN, serIn, serOut, clrN, ldN, rselN, hot, alarmN, span60, pdGnd;
   qdac_chan_s [3:0] chanOut;
   logic [15:0] rd;
   int bad_count = 0;
   int tests_run = 0;
   int cyc = 0;
   qdac_serial_update uut(.clk(clk), .rst_n(rst_n), .shift_clock(sclk), .frame_select_n(fsN),
      .serial_in(serIn), .serial_out(serOut), .async_clear_n(clrN), .load_outputs_n(ldN),
      .range_select_n(rselN), .overTempDetect(hot), .alarmOut_n(alarmN), .span60Sel(span60),
      .pdGroundMode(pdGnd), .chanOut(chanOut));
   qdac_host_model host(.sclk(sclk), .fsN(fsN), .serIn(serIn), .serOut(serOut));
   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   function automatic logic [15:0] cd(input int i);
      return {4'h0, chanOut[i].code};
   endfunction
   function automatic logic [15:0] pw();
      return {12'h0, chanOut[3].powered, chanOut[2].powered, chanOut[1].powered,
         chanOut[0].powered};
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      if (bad_count == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Frame plus the spacing needed before the next commit
   task automatic fr(input logic [15:0] w, input int n);
      host.xfer(w, n, rd);
      wt(6);
   endtask
   task automatic rdb(input logic [15:0] cmd, input logic [15:0] exp);
      fr(cmd, 16);
      fr(16'h0000, 16);
      chk(rd, exp);
   endtask
   task automatic pulse();
      ldN = 0;
      wt(3);
      ldN = 1;
      wt(3);
   endtask
   task automatic t_reset();
      chk({13'h0, alarmN, span60, pdGnd}, 16'h0005);
      chk(pw(), 16'h0000);
      rdb(16'hF000, 16'h7040);
   endtask
   task automatic t_load();
      for (int i = 0; i < 4; i++) begin
         fr({1'b0, 3'(i + 1), 12'hA50 + 12'(i)}, 16);
         chk(cd(i), 16'h0000);
      end
      pulse();
      for (int i = 0; i < 4; i++) begin
         chk(cd(i), 16'h0A50 + 16'(i));
      end
      rdb(16'hA000, 16'h2A51);
      fr(16'h1123, 15);
      pulse();
      chk(cd(0), 16'h0A50);
   endtask
   task automatic t_clear();
      fr(16'h4FFF, 16);
      clrN = 0;
      wt(6);
      chk(cd(3), 16'h0000);
      ldN = 0;
      fr(16'h37E1, 16);
      chk(cd(2), 16'h0000);
      ldN = 1;
      wt(3);
      clrN = 1;
      wt(3);
      pulse();
      chk(cd(2), 16'h07E1);
      chk(cd(3), 16'h0000);
   endtask
   task automatic t_tied();
      ldN = 0;
      wt(3);
      fr(16'h15AA, 16);
      wt(2);
      chk(cd(0), 16'h05AA);
      ldN = 1;
   endtask
   task automatic t_pins();
      rselN = 0;
      wt(5);
      chk({15'h0, span60}, 16'h0001);
      rselN = 1;
      wt(5);
      chk({15'h0, span60}, 16'h0000);
      fr(16'h703C, 16);
      chk(pw(), 16'h000F);
      hot = 1;
      wt(6);
      chk({15'h0, alarmN}, 16'h0000);
      chk(pw(), 16'h0000);
      hot = 0;
      wt(6);
      chk({15'h0, alarmN}, 16'h0001);
      rdb(16'hF000, 16'h7000);
      fr(16'h707C, 16);
      chk({pw()}, 16'h000F);
   endtask
   // Reset falls after time zero so the link word flops see their reset edge
   initial begin
      rst_n = 1;
      #1 rst_n = 0;
      clrN = 1;
      ldN = 1;
      rselN = 1;
      hot = 0;
      wt(20);
      rst_n = 1;
      wt(3);
      t_reset();
      t_load();
      t_clear();
      t_tied();
      t_pins();
      end_of_test();
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         end_of_test();
      end
   end
endmodule
